// [src/sbst_pkg.sv]
// Purpose: shared constants and types for the sample buffer and scan interval timer
// Assumes: one 250 MHz clock, register addresses as seen on page 3 of the control port
// Notes:   counts of timer ticks that exceed 4096 are top-level parameters
package sbst_pkg;

  // ------------------------------------------------------------
  // widths and types
  // ------------------------------------------------------------
  localparam int unsigned WORD_W  = 12;
  localparam int unsigned DEPTH   = 64;
  localparam int unsigned AW      = 6;
  typedef logic [WORD_W-1:0] sbst_word_t;
  typedef logic [7:0]        sbst_byte_t;
  typedef logic [AW:0]       sbst_ptr_t;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam sbst_byte_t OFS_RESERVED_A   = 8'h0b;
  localparam sbst_byte_t OFS_RESERVED_B   = 8'h0c;
  localparam sbst_byte_t OFS_BUF_CTRL     = 8'h0d;
  localparam sbst_byte_t OFS_RESERVED_C   = 8'h0e;
  localparam sbst_byte_t OFS_TIMER_CTRL   = 8'h0f;
  localparam sbst_byte_t OFS_TIMER_CLK    = 8'h10;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam sbst_byte_t RST_RESERVED_A   = 8'h00;
  localparam sbst_byte_t RST_RESERVED_B   = 8'h00;
  localparam sbst_byte_t RST_BUF_CTRL     = 8'h00;
  localparam sbst_byte_t RST_RESERVED_C   = 8'h0f;
  localparam sbst_byte_t RST_TIMER_CTRL   = 8'h40;
  localparam sbst_byte_t RST_TIMER_CLK    = 8'h81;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned BC_EN           = 7;
  localparam int unsigned BC_SINGLE       = 6;
  localparam int unsigned BC_LVL_LO       = 3;
  localparam int unsigned BC_RSVD         = 2;
  localparam int unsigned BC_FULL         = 1;
  localparam int unsigned BC_EMPTY        = 0;
  localparam int unsigned TC_TOUCH_EN     = 7;
  localparam int unsigned TC_TOUCH_LO     = 4;
  localparam int unsigned TC_LONG_EN      = 3;
  localparam int unsigned TC_LONG_LO      = 0;
  localparam int unsigned CK_SEL_MCLK     = 7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned TICK_MHZ        = 1;
  localparam int unsigned TOUCH_CODE0_MS  = 8;
  localparam int unsigned MS_TICKS_DFLT   = 1000 * TICK_MHZ;
  localparam int unsigned LONG_UNIT_DFLT  = 32'h0400_0000;
  localparam int unsigned OSC_DIV         = 8;
  localparam int unsigned LVL_STEP        = 8;

  typedef enum logic [1:0] {
    SBST_T_IDLE = 2'b00,
    SBST_T_WAIT = 2'b01,
    SBST_T_GO   = 2'b11
  } sbst_tstate_e;

endpackage

// [src/sbst_buf_mem.sv]
// Purpose: 64-word sample store with registered read data
// Assumes: one write and one read port on the same clock
// Notes:   contents are not reset; only pointers define valid words
`timescale 1ns/1ns
`default_nettype none
module sbst_buf_mem (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            wr_en,
  input  wire logic [5:0]      wr_addr,
  input  wire sbst_pkg::sbst_word_t wr_data,
  input  wire logic            rd_en,
  input  wire logic [5:0]      rd_addr,
  output logic                 rd_valid_q,
  output sbst_pkg::sbst_word_t rd_data_q
);
  import sbst_pkg::*;

  sbst_word_t mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= mem[rd_addr];
      end
    end
  end

endmodule // sbst_buf_mem
`default_nettype wire

// [src/sbst_top.sv]
// Purpose: sample buffer control and scan interval timer of the converter sequencer
// Assumes: register port and sample strobes on clk_sys; osc_clk_in is a raw pin
// Notes:   flags and trigger follow the pointers one cycle late
`timescale 1ns/1ns
`default_nettype none
module sbst_top #(
  parameter int unsigned MS_TICKS  = sbst_pkg::MS_TICKS_DFLT,
  parameter int unsigned LONG_UNIT = sbst_pkg::LONG_UNIT_DFLT
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire sbst_pkg::sbst_byte_t reg_addr,
  input  wire sbst_pkg::sbst_byte_t reg_wdata,
  input  wire logic                 reg_we,
  input  wire logic                 reg_re,
  output sbst_pkg::sbst_byte_t      reg_rdata_q,
  input  wire logic                 conv_valid,
  input  wire sbst_pkg::sbst_word_t conv_data,
  input  wire logic                 buf_rd_req,
  output logic                      buf_rd_valid_q,
  output sbst_pkg::sbst_word_t      buf_rd_data_q,
  output logic                      conv_hold_q,
  output logic                      trigger_q,
  output logic                      chan_flags_valid_q,
  input  wire logic                 osc_clk_in,
  input  wire logic                 set_done,
  input  wire logic                 set_is_touch,
  input  wire logic                 self_mode,
  input  wire logic                 host_seq_xy,
  output logic                      scan_wait_q,
  output logic                      scan_start_q
);
  import sbst_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  sbst_byte_t   rsvd_a_q, rsvd_b_q, rsvd_c_q, buf_ctrl_q, tmr_ctrl_q, tmr_clk_q;
  sbst_ptr_t    buffer_write_pointer_q, buffer_read_pointer_q, buffer_trigger_pointer_q;
  sbst_ptr_t    count, trig_diff;
  logic         full_q, empty_q;
  logic         buf_en, single, wr_ok, rd_ok;
  logic [6:0]   level;

  assign buf_en = buf_ctrl_q[BC_EN];
  assign single = buf_ctrl_q[BC_SINGLE];
  assign level  = 7'((buf_ctrl_q[BC_LVL_LO +: 3] + 4'h1) * LVL_STEP);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsvd_a_q   <= RST_RESERVED_A;
      rsvd_b_q   <= RST_RESERVED_B;
      buf_ctrl_q <= RST_BUF_CTRL;
      rsvd_c_q   <= RST_RESERVED_C;
      tmr_ctrl_q <= RST_TIMER_CTRL;
      tmr_clk_q  <= RST_TIMER_CLK;
    end else if (reg_we) begin
      unique case (reg_addr)
        OFS_RESERVED_A: rsvd_a_q   <= reg_wdata;
        OFS_RESERVED_B: rsvd_b_q   <= reg_wdata;
        OFS_BUF_CTRL:   buf_ctrl_q <= {reg_wdata[7:2], 2'h0};
        OFS_RESERVED_C: rsvd_c_q   <= reg_wdata;
        OFS_TIMER_CTRL: tmr_ctrl_q <= reg_wdata;
        OFS_TIMER_CLK:  tmr_clk_q  <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        OFS_RESERVED_A: reg_rdata_q <= rsvd_a_q;
        OFS_RESERVED_B: reg_rdata_q <= rsvd_b_q;
        OFS_BUF_CTRL:   reg_rdata_q <= {buf_ctrl_q[7:2], full_q, empty_q};
        OFS_RESERVED_C: reg_rdata_q <= rsvd_c_q;
        OFS_TIMER_CTRL: reg_rdata_q <= tmr_ctrl_q;
        OFS_TIMER_CLK:  reg_rdata_q <= tmr_clk_q;
        default:        reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // buffer pointers
  // ------------------------------------------------------------
  assign count     = buffer_write_pointer_q - buffer_read_pointer_q;
  assign trig_diff = buffer_write_pointer_q - buffer_trigger_pointer_q;
  // a full buffer drops new words so unread data is never overwritten
  assign wr_ok = buf_en && conv_valid && (count != 7'(DEPTH)) && !conv_hold_q;
  assign rd_ok = buf_en && buf_rd_req && (count != 7'h00);

  always_ff @(posedge clk_sys) begin
    if (rst || !buf_en) begin
      buffer_write_pointer_q   <= 7'h00;
      buffer_read_pointer_q    <= 7'h00;
      buffer_trigger_pointer_q <= 7'h08;
    end else begin
      if (wr_ok) begin
        buffer_write_pointer_q <= buffer_write_pointer_q + 7'h01;
      end
      if (rd_ok) begin
        buffer_read_pointer_q <= buffer_read_pointer_q + 7'h01;
      end
      buffer_trigger_pointer_q <= buffer_read_pointer_q + 7'(rd_ok) + level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      full_q  <= (count == 7'(DEPTH));
      empty_q <= (count == 7'h00);
    end
  end

  // trigger pointer lags one cycle after a level change; sign bit tells count vs level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trigger_q          <= 1'b0;
      conv_hold_q        <= 1'b0;
      chan_flags_valid_q <= 1'b1;
    end else begin
      trigger_q          <= buf_en && !trig_diff[AW] && (count != 7'h00);
      chan_flags_valid_q <= !buf_en;
      if (!buf_en) begin
        conv_hold_q <= 1'b0;
      end else if (single) begin
        // single-shot: stop after one trigger-level batch until drained
        conv_hold_q <= (conv_hold_q && count != 7'h00) || trigger_q;
      end else begin
        conv_hold_q <= 1'b0;
      end
    end
  end

  sbst_buf_mem u_mem (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .wr_en      (wr_ok),
    .wr_addr    (buffer_write_pointer_q[AW-1:0]),
    .wr_data    (conv_data),
    .rd_en      (rd_ok),
    .rd_addr    (buffer_read_pointer_q[AW-1:0]),
    .rd_valid_q (buf_rd_valid_q),
    .rd_data_q  (buf_rd_data_q)
  );

  // ------------------------------------------------------------
  // timer tick sources
  // ------------------------------------------------------------
  logic       osc_s1_q, osc_s2_q, osc_s3_q, tick_q;
  logic [6:0] mdiv_q;
  logic [2:0] odiv_q;
  logic [7:0] mdiv_max;

  assign mdiv_max = (tmr_clk_q[6:0] == 7'h00) ? 8'h7f : {1'b0, tmr_clk_q[6:0] - 7'h01};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mdiv_q <= 7'h00;
      odiv_q <= 3'h0;
      tick_q <= 1'b0;
    end else if (tmr_clk_q[CK_SEL_MCLK]) begin
      tick_q <= ({1'b0, mdiv_q} == mdiv_max);
      mdiv_q <= ({1'b0, mdiv_q} == mdiv_max) ? 7'h00 : mdiv_q + 7'h01;
    end else begin
      // oscillator rising edges over eight give the nominal tick, so delays track it
      tick_q <= osc_s2_q && !osc_s3_q && (odiv_q == 3'(OSC_DIV - 1));
      if (osc_s2_q && !osc_s3_q) begin
        odiv_q <= odiv_q + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // interval timer
  // ------------------------------------------------------------
  sbst_tstate_e tstate_q;
  logic [31:0]  tcnt_q, touch_ticks, long_ticks;
  logic [2:0]   tcode, lcode;
  logic         delay_on;

  assign tcode       = tmr_ctrl_q[TC_TOUCH_LO +: 3];
  assign lcode       = tmr_ctrl_q[TC_LONG_LO +: 3];
  assign touch_ticks = (tcode == 3'h0) ? 32'(TOUCH_CODE0_MS * MS_TICKS)
                                       : 32'(tcode) * 32'(MS_TICKS);
  assign long_ticks  = 32'({lcode, 1'b1}) * 32'(LONG_UNIT);
  assign delay_on    = (self_mode || host_seq_xy) &&
                       (set_is_touch ? tmr_ctrl_q[TC_TOUCH_EN]
                                     : tmr_ctrl_q[TC_LONG_EN]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tstate_q <= SBST_T_IDLE;
      tcnt_q   <= 32'h0;
    end else begin
      unique case (tstate_q)
        SBST_T_IDLE: begin
          if (set_done) begin
            tstate_q <= delay_on ? SBST_T_WAIT : SBST_T_GO;
            tcnt_q   <= set_is_touch ? touch_ticks : long_ticks;
          end
        end
        SBST_T_WAIT: begin
          if (tick_q) begin
            tcnt_q <= tcnt_q - 32'h1;
            if (tcnt_q <= 32'h1) begin
              tstate_q <= SBST_T_GO;
            end
          end
        end
        SBST_T_GO: tstate_q <= SBST_T_IDLE;
        default:   tstate_q <= SBST_T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_wait_q  <= 1'b0;
      scan_start_q <= 1'b0;
    end else begin
      scan_wait_q  <= (tstate_q == SBST_T_WAIT);
      scan_start_q <= (tstate_q == SBST_T_GO);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_disable_ptrs: assert property (@(posedge clk_sys) disable iff (rst)
    !buf_en |=> buffer_write_pointer_q == 7'h00 && buffer_read_pointer_q == 7'h00)
    else $error("pointers not cleared while buffer disabled");
  a_full_flag: assert property (@(posedge clk_sys) disable iff (rst)
    full_q == ($past(buffer_write_pointer_q) - $past(buffer_read_pointer_q) == 7'h40))
    else $error("full flag disagrees with word count");
  a_empty_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (count == 7'h00) |=> empty_q)
    else $error("empty flag not set on empty buffer");
  a_no_overfill: assert property (@(posedge clk_sys) disable iff (rst)
    count <= 7'h40)
    else $error("buffer holds more than 64 words");
  a_trig_level: assert property (@(posedge clk_sys) disable iff (rst)
    trigger_q |-> $past(count) >= $past(level))
    else $error("trigger raised below level");
  a_single_hold: assert property (@(posedge clk_sys) disable iff (rst)
    buf_en && single && trigger_q && $stable(buf_ctrl_q) |=> conv_hold_q)
    else $error("single-shot did not hold after trigger");
  a_cont_nohold: assert property (@(posedge clk_sys) disable iff (rst)
    buf_en && !single |=> !conv_hold_q)
    else $error("continuous mode held conversions");
  a_no_delay: assert property (@(posedge clk_sys) disable iff (rst)
    tstate_q == SBST_T_IDLE && set_done && !delay_on |-> ##2 scan_start_q)
    else $error("start not immediate without delay");
  a_delay_waits: assert property (@(posedge clk_sys) disable iff (rst)
    tstate_q == SBST_T_IDLE && set_done && delay_on |=> ##1 scan_wait_q [*3])
    else $error("enabled delay did not wait");
  a_mdiv_gap: assert property (@(posedge clk_sys) disable iff (rst)
    tick_q && tmr_clk_q == 8'h82 && $stable(tmr_clk_q) |=> !tick_q ##1 tick_q)
    else $error("divide-by-two tick spacing wrong");

endmodule // sbst_top
`default_nettype wire

// [tb/sbst_host_model.sv]
// Purpose: host side of the register port and the buffer pop strobe
// Assumes: requests launched just after an edge and held over one edge
// Notes:   reserved places only ever receive their reset contents
`timescale 1ns/1ns
`default_nettype none
module sbst_host_model (
  input  wire logic                 clk_sys,
  output sbst_pkg::sbst_byte_t      reg_addr,
  output sbst_pkg::sbst_byte_t      reg_wdata,
  output logic                      reg_we,
  output logic                      reg_re,
  input  wire sbst_pkg::sbst_byte_t reg_rdata_q,
  output logic                      buf_rd_req,
  input  wire logic                 buf_rd_valid_q,
  input  wire sbst_pkg::sbst_word_t buf_rd_data_q
);
  import sbst_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    buf_rd_req = 1'b0;
  end
  // ------------------------------------------------------------
  // host accesses
  // ------------------------------------------------------------
  task automatic wr(input sbst_byte_t a, input sbst_byte_t d);
    sbst_byte_t v;
    v = d;
    if (a == OFS_RESERVED_A) v = RST_RESERVED_A;
    if (a == OFS_RESERVED_B) v = RST_RESERVED_B;
    if (a == OFS_RESERVED_C) v = RST_RESERVED_C;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    // released bus must not keep looking valid
    reg_wdata <= ~v;
  endtask
  task automatic rd(input sbst_byte_t a, output sbst_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
  endtask
  task automatic pop(output logic v, output sbst_word_t d);
    @(posedge clk_sys);
    buf_rd_req <= 1'b1;
    @(posedge clk_sys);
    buf_rd_req <= 1'b0;
    #1;
    v = buf_rd_valid_q;
    d = buf_rd_data_q;
  endtask
endmodule // sbst_host_model
`default_nettype wire

// [tb/tb_sbst_top.sv]
// Purpose: self-checking bench for the sample buffer and scan timer
// Assumes: small MS_TICKS and LONG_UNIT keep timer runs short
// Notes:   register and pop traffic goes through the host model
`timescale 1ns/1ns
`default_nettype none
module tb_sbst_top;
  import sbst_pkg::*;
  localparam int unsigned MS = 4;
  localparam int unsigned LU = 4;
  logic       clk_sys, rst, reg_we, reg_re, conv_valid, buf_rd_req, buf_rd_valid_q;
  logic       conv_hold_q, trigger_q, chan_flags_valid_q, osc_clk_in, set_done;
  logic       set_is_touch, self_mode, host_seq_xy, scan_wait_q, scan_start_q;
  sbst_byte_t reg_addr, reg_wdata, reg_rdata_q;
  sbst_word_t conv_data, buf_rd_data_q;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  sbst_top #(.MS_TICKS(MS), .LONG_UNIT(LU)) i_sbst_top (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q), .conv_valid(conv_valid), .conv_data(conv_data),
    .buf_rd_req(buf_rd_req), .buf_rd_valid_q(buf_rd_valid_q),
    .buf_rd_data_q(buf_rd_data_q), .conv_hold_q(conv_hold_q), .trigger_q(trigger_q),
    .chan_flags_valid_q(chan_flags_valid_q), .osc_clk_in(osc_clk_in),
    .set_done(set_done), .set_is_touch(set_is_touch), .self_mode(self_mode),
    .host_seq_xy(host_seq_xy), .scan_wait_q(scan_wait_q), .scan_start_q(scan_start_q));
  sbst_host_model i_sbst_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
    .buf_rd_req(buf_rd_req), .buf_rd_valid_q(buf_rd_valid_q),
    .buf_rd_data_q(buf_rd_data_q));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // slow free-running oscillator, five clk_sys periods long, its rising edges on clk_sys rising edges
  initial begin
    osc_clk_in = 1'b0;
    forever #10 osc_clk_in = ~osc_clk_in;
  end
  // ------------------------------------------------------------
  // compare and helper tasks
  // ------------------------------------------------------------
  task automatic chk_b(input sbst_byte_t got, input sbst_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_w(input sbst_word_t got, input sbst_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t value %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rdchk(input sbst_byte_t a, input sbst_byte_t exp);
    sbst_byte_t d;
    @(posedge clk_sys);
    i_sbst_host_model.rd(a, d);
    chk_b(d, exp);
  endtask
  // flags lag the pointers, so settle before returning
  task automatic push(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      conv_valid <= 1'b1;
      conv_data <= sbst_word_t'(base + i);
    end
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic drain(input int n, input int base);
    logic v;
    sbst_word_t d;
    for (int i = 0; i < n; i++) begin
      i_sbst_host_model.pop(v, d);
      chk_n(v, 1);
      chk_w(d, sbst_word_t'(base + i));
    end
    i_sbst_host_model.pop(v, d);
    chk_n(v, 0);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk(OFS_RESERVED_A, 8'h00);
    rdchk(OFS_BUF_CTRL, 8'h01);
    rdchk(OFS_RESERVED_C, 8'h0f);
    rdchk(OFS_TIMER_CTRL, 8'h40);
    rdchk(OFS_TIMER_CLK, 8'h81);
    rdchk(8'h20, 8'h00);
    chk_n(chan_flags_valid_q, 1);
    i_sbst_host_model.wr(OFS_RESERVED_C, 8'hff);
    rdchk(OFS_RESERVED_C, 8'h0f);
    i_sbst_host_model.wr(OFS_RESERVED_B, 8'h5a);
    rdchk(OFS_RESERVED_B, 8'h00);
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'h07);
    rdchk(OFS_BUF_CTRL, 8'h05);
    i_sbst_host_model.wr(OFS_TIMER_CTRL, 8'ha5);
    rdchk(OFS_TIMER_CTRL, 8'ha5);
  endtask
  task automatic t_trigger;
    logic v;
    sbst_word_t d;
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'h80);
    push(7, 0);
    chk_n(chan_flags_valid_q, 0);
    chk_n(trigger_q, 0);
    push(1, 7);
    chk_n(trigger_q, 1);
    chk_n(conv_hold_q, 0);
    rdchk(OFS_BUF_CTRL, 8'h80);
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'h00);
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'h80);
    rdchk(OFS_BUF_CTRL, 8'h81);
    chk_n(trigger_q, 0);
    i_sbst_host_model.pop(v, d);
    chk_n(v, 0);
  endtask
  task automatic t_full;
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'hb8);
    push(63, 100);
    chk_n(trigger_q, 0);
    rdchk(OFS_BUF_CTRL, 8'hb8);
    push(2, 163);
    chk_n(trigger_q, 1);
    rdchk(OFS_BUF_CTRL, 8'hba);
    drain(64, 100);
    rdchk(OFS_BUF_CTRL, 8'hb9);
  endtask
  // hold registers two cycles after the eighth word, so the ninth still lands
  task automatic t_single;
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'hc0);
    push(9, 20);
    chk_n(conv_hold_q, 1);
    push(1, 40);
    drain(9, 20);
    repeat (3) @(posedge clk_sys);
    #1;
    chk_n(conv_hold_q, 0);
    i_sbst_host_model.wr(OFS_BUF_CTRL, 8'h00);
  endtask
  task automatic tcase(input sbst_byte_t tc, input sbst_byte_t ck, input logic tch,
                       input logic sm, input logic xy, input int exp, input int tol);
    int w;
    int s;
    w = 0;
    s = 0;
    i_sbst_host_model.wr(OFS_TIMER_CTRL, tc);
    i_sbst_host_model.wr(OFS_TIMER_CLK, ck);
    @(posedge clk_sys);
    set_done <= 1'b1;
    set_is_touch <= tch;
    self_mode <= sm;
    host_seq_xy <= xy;
    @(posedge clk_sys);
    set_done <= 1'b0;
    for (int k = 1; k < 2000 && s == 0; k++) begin
      #1;
      if (scan_wait_q === 1'b1)
        w++;
      if (scan_start_q === 1'b1)
        s = k;
      else
        @(posedge clk_sys);
    end
    if (exp == 0)
      chk_n(w, 0);
    else
      chk_n(w + tol >= exp && w <= exp + tol, 1);
    chk_n(s, w + 2);
  endtask
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_data = '0;
    set_done = 1'b0;
    set_is_touch = 1'b0;
    self_mode = 1'b0;
    host_seq_xy = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_trigger();
    t_full();
    t_single();
    tcase(8'h90, 8'h81, 1, 1, 0, 4, 1);
    tcase(8'h80, 8'h81, 1, 1, 0, 32, 1);
    tcase(8'hf0, 8'h81, 1, 1, 0, 28, 1);
    tcase(8'h10, 8'h81, 1, 1, 0, 0, 0);
    tcase(8'h90, 8'h81, 1, 0, 0, 0, 0);
    tcase(8'h90, 8'h81, 1, 0, 1, 4, 1);
    tcase(8'h08, 8'h81, 0, 1, 0, 4, 1);
    tcase(8'h0b, 8'h81, 0, 1, 0, 28, 1);
    tcase(8'h08, 8'h81, 1, 1, 0, 0, 0);
    tcase(8'h80, 8'h81, 0, 1, 0, 0, 0);
    tcase(8'h90, 8'h82, 1, 1, 0, 8, 2);
    tcase(8'h90, 8'h80, 1, 1, 0, 512, 128);
    tcase(8'h90, 8'h01, 1, 1, 0, 160, 45);
    give_verdict();
  end
  initial begin
    forever begin
      @(posedge clk_sys);
      cycles++;
      if (cycles >= 30000) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        give_verdict();
      end
    end
  end
endmodule // tb_sbst_top
`default_nettype wire
